// *** hw/mpgc_top.sv ***
// Multi-port GPIO control: latches, direction, pull-up and segment select.
// Assumes pad inputs are asynchronous and the CPU bus is on sys_clk.
`timescale 1ns/10ps
`default_nettype none

// Behaviour
// - Port0 eight bits, latch, per-bit direction
// - Reset loads all direction registers FF
// - Direction zero drives latch, one inputs
// - Reset clears all pull-up selects
// - Pull-up only when selected and input
// - Pull-up bit one connects, zero not
// - Unbacked direction bits read fixed one
// - Ports 1,2,3 widths 2,6,5
// - Port5 open-drain, only pulls low
// - Port5 has no software pull-up
// - Port6 eight-bit input only
// - Port7 input valid only port pins
// - Port8 segment pins ignore direction
// - Irq detectors watch pins in output
// - Direction accepts bit and byte writes
// - Read gives latch or pin level
// - Input-mode write updates latch only
// - Segment select one means segment, resets zero
module mpgc_top (
  input  wire logic               sys_clk,
  input  wire logic               rst_n,
  input  wire mpgc_pkg::mpgc_req_t bus_req,
  output var  logic [7:0]         bus_rdata,
  input  wire mpgc_pkg::mpgc_pads_t pad_in,
  input  wire logic [7:0]         p6_in,
  input  wire logic [3:0]         p7_in,
  output var  mpgc_pkg::mpgc_pads_t pad_out,
  output var  mpgc_pkg::mpgc_pads_t pad_oe_n,
  output var  mpgc_pkg::mpgc_pads_t pullup_en,
  output var  logic [3:0]         ext_irq_pins,
  output var  logic [7:0]         key_return_inputs,
  output var  logic [3:0]         port7_segment_select,
  output var  logic [7:0]         port8_segment_select
);

  // Byte merge for bit writes; bmask 1 selects the bit to change
  function automatic logic [7:0] merge(input logic [7:0] old, input logic [7:0] wd,
                                       input logic [7:0] m);
    merge = (old & ~m) | (wd & m);
  endfunction

  // Two-flop synchronisers on all pad inputs
  mpgc_pkg::mpgc_pads_t pad_s1_r, pad_s2_r;
  logic [7:0] p6_s1_r, p6_s2_r;
  logic [3:0] p7_s1_r, p7_s2_r;
  always_ff @(posedge sys_clk) begin
    pad_s1_r <= pad_in;
    pad_s2_r <= pad_s1_r;
    p6_s1_r  <= p6_in;
    p6_s2_r  <= p6_s1_r;
    p7_s1_r  <= p7_in;
    p7_s2_r  <= p7_s1_r;
  end

  // Control state
  mpgc_pkg::mpgc_pads_t lat_r, lat_nxt, dir_r, dir_nxt;
  logic [7:0] pu0_r, pu1_r, pu2_r, pu3_r, pu0_nxt, pu1_nxt, pu2_nxt, pu3_nxt;
  logic [3:0] seg7_r, seg7_nxt;
  logic [7:0] seg8_r, seg8_nxt;

  // Next-state of all software-written registers
  always_comb begin
    lat_nxt  = lat_r;
    dir_nxt  = dir_r;
    pu0_nxt  = pu0_r;
    pu1_nxt  = pu1_r;
    pu2_nxt  = pu2_r;
    pu3_nxt  = pu3_r;
    seg7_nxt = seg7_r;
    seg8_nxt = seg8_r;
    if (bus_req.wr) begin
      case (bus_req.addr)
        // Latch takes the write in either mode; pin follows only in output mode
        mpgc_pkg::ADDR_P0:   lat_nxt.p0 = bus_req.wdata;
        mpgc_pkg::ADDR_P1:   lat_nxt.p1 = bus_req.wdata[1:0];
        mpgc_pkg::ADDR_P2:   lat_nxt.p2 = bus_req.wdata[5:0];
        mpgc_pkg::ADDR_P3:   lat_nxt.p3 = bus_req.wdata[4:0];
        mpgc_pkg::ADDR_P5:   lat_nxt.p5 = bus_req.wdata[3:0];
        mpgc_pkg::ADDR_P8:   lat_nxt.p8 = bus_req.wdata;
        // Direction writes honour the bit mask for single-bit writes
        mpgc_pkg::ADDR_DIR0: dir_nxt.p0 = merge(dir_r.p0, bus_req.wdata,
                                                bus_req.bmask);
        mpgc_pkg::ADDR_DIR1: dir_nxt.p1 = 2'(merge({6'h3f, dir_r.p1}, bus_req.wdata,
                                                   bus_req.bmask));
        mpgc_pkg::ADDR_DIR2: dir_nxt.p2 = 6'(merge({2'h3, dir_r.p2}, bus_req.wdata,
                                                   bus_req.bmask));
        mpgc_pkg::ADDR_DIR3: dir_nxt.p3 = 5'(merge({3'h7, dir_r.p3}, bus_req.wdata,
                                                   bus_req.bmask));
        mpgc_pkg::ADDR_DIR5: dir_nxt.p5 = 4'(merge({4'hf, dir_r.p5}, bus_req.wdata,
                                                   bus_req.bmask));
        mpgc_pkg::ADDR_DIR8: dir_nxt.p8 = merge(dir_r.p8, bus_req.wdata, bus_req.bmask);
        mpgc_pkg::ADDR_PU0:  pu0_nxt = merge(pu0_r, bus_req.wdata, bus_req.bmask);
        mpgc_pkg::ADDR_PU1:  pu1_nxt = merge(pu1_r, bus_req.wdata, bus_req.bmask)
                                       & 8'h03;
        mpgc_pkg::ADDR_PU2:  pu2_nxt = merge(pu2_r, bus_req.wdata, bus_req.bmask)
                                       & 8'h3f;
        mpgc_pkg::ADDR_PU3:  pu3_nxt = merge(pu3_r, bus_req.wdata, bus_req.bmask)
                                       & 8'h1f;
        mpgc_pkg::ADDR_SEG7: seg7_nxt = bus_req.wdata[3:0];
        mpgc_pkg::ADDR_SEG8: seg8_nxt = bus_req.wdata;
        default: ;
      endcase
    end
  end

  // Register stage; reset puts all pins in input mode with no pull-ups
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      lat_r  <= '0;
      dir_r  <= '1;
      pu0_r  <= mpgc_pkg::PU_RST;
      pu1_r  <= mpgc_pkg::PU_RST;
      pu2_r  <= mpgc_pkg::PU_RST;
      pu3_r  <= mpgc_pkg::PU_RST;
      seg7_r <= mpgc_pkg::SEG_RST[3:0];
      seg8_r <= mpgc_pkg::SEG_RST;
    end else begin
      lat_r  <= lat_nxt;
      dir_r  <= dir_nxt;
      pu0_r  <= pu0_nxt;
      pu1_r  <= pu1_nxt;
      pu2_r  <= pu2_nxt;
      pu3_r  <= pu3_nxt;
      seg7_r <= seg7_nxt;
      seg8_r <= seg8_nxt;
    end
  end

  // Read mux: latch for output bits, synchronised pin for input bits
  function automatic logic [7:0] rdmix(input logic [7:0] lat, input logic [7:0] dir,
                                       input logic [7:0] pin);
    rdmix = (lat & ~dir) | (pin & dir);
  endfunction

  logic [7:0] rdata_nxt;
  always_comb begin
    rdata_nxt = 8'h00;
    if (bus_req.rd) begin
      case (bus_req.addr)
        mpgc_pkg::ADDR_P0:   rdata_nxt = rdmix(lat_r.p0, dir_r.p0, pad_s2_r.p0);
        mpgc_pkg::ADDR_P1:   rdata_nxt = rdmix({6'h0, lat_r.p1}, {6'h0, dir_r.p1},
                                               {6'h0, pad_s2_r.p1});
        mpgc_pkg::ADDR_P2:   rdata_nxt = rdmix({2'h0, lat_r.p2}, {2'h0, dir_r.p2},
                                               {2'h0, pad_s2_r.p2});
        mpgc_pkg::ADDR_P3:   rdata_nxt = rdmix({3'h0, lat_r.p3}, {3'h0, dir_r.p3},
                                               {3'h0, pad_s2_r.p3});
        mpgc_pkg::ADDR_P5:   rdata_nxt = rdmix({4'h0, lat_r.p5}, {4'h0, dir_r.p5},
                                               {4'h0, pad_s2_r.p5});
        mpgc_pkg::ADDR_P6:   rdata_nxt = p6_s2_r;
        // Segment pins read as zero
        mpgc_pkg::ADDR_P7:   rdata_nxt = {4'h0, p7_s2_r & ~seg7_r};
        mpgc_pkg::ADDR_P8:   rdata_nxt = rdmix(lat_r.p8, dir_r.p8 | seg8_r,
                                               pad_s2_r.p8) & ~seg8_r;
        mpgc_pkg::ADDR_DIR0: rdata_nxt = dir_r.p0;
        // Bits with no pin behind them read as one
        mpgc_pkg::ADDR_DIR1: rdata_nxt = {6'h3f, dir_r.p1};
        mpgc_pkg::ADDR_DIR2: rdata_nxt = {2'h3, dir_r.p2};
        mpgc_pkg::ADDR_DIR3: rdata_nxt = {3'h7, dir_r.p3};
        mpgc_pkg::ADDR_DIR5: rdata_nxt = {4'hf, dir_r.p5};
        mpgc_pkg::ADDR_DIR8: rdata_nxt = dir_r.p8;
        mpgc_pkg::ADDR_PU0:  rdata_nxt = pu0_r;
        mpgc_pkg::ADDR_PU1:  rdata_nxt = pu1_r;
        mpgc_pkg::ADDR_PU2:  rdata_nxt = pu2_r;
        mpgc_pkg::ADDR_PU3:  rdata_nxt = pu3_r;
        default:             rdata_nxt = 8'h00;
      endcase
    end
  end

  // Pad-facing combinational values, registered below
  mpgc_pkg::mpgc_pads_t out_nxt, oen_nxt, pu_nxt;
  always_comb begin
    out_nxt    = lat_r;
    oen_nxt    = dir_r;
    // Open-drain: drive only when output and latch low, never high
    out_nxt.p5 = 4'h0;
    oen_nxt.p5 = dir_r.p5 | lat_r.p5;
    // Segment-owned pins never drive as port
    oen_nxt.p8 = dir_r.p8 | seg8_r;
    // Pull-up needs select bit and input mode
    pu_nxt.p0  = pu0_r & dir_r.p0;
    pu_nxt.p1  = pu1_r[1:0] & dir_r.p1;
    pu_nxt.p2  = pu2_r[5:0] & dir_r.p2;
    pu_nxt.p3  = pu3_r[4:0] & dir_r.p3;
    pu_nxt.p5  = 4'h0;
    pu_nxt.p8  = 8'h00;
  end

  // All outputs come from flip-flops
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      bus_rdata            <= 8'h00;
      pad_out              <= '0;
      pad_oe_n             <= '1;
      pullup_en            <= '0;
      ext_irq_pins         <= 4'h0;
      key_return_inputs    <= 8'h00;
      port7_segment_select <= 4'h0;
      port8_segment_select <= 8'h00;
    end else begin
      bus_rdata            <= rdata_nxt;
      pad_out              <= out_nxt;
      pad_oe_n             <= oen_nxt;
      pullup_en            <= pu_nxt;
      // Detectors see the pin even in output mode; software must mask first
      ext_irq_pins         <= pad_s2_r.p3[3:0];
      key_return_inputs    <= pad_s2_r.p0;
      port7_segment_select <= seg7_r;
      port8_segment_select <= seg8_r;
    end
  end

  // Checks
  a_dir_reset: assert property (@(posedge sys_clk) !rst_n |=> pad_oe_n == '1)
    else $error("pads not in input after reset");
  a_pu_reset: assert property (@(posedge sys_clk) !rst_n |=> pullup_en == '0)
    else $error("pull-up active after reset");
  a_pu_output: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !pad_oe_n.p0[0] |-> !pullup_en.p0[0])
    else $error("pull-up on output pin");
  a_od_never_high: assert property (@(posedge sys_clk) disable iff (!rst_n)
    pad_out.p5 == 4'h0)
    else $error("open-drain driven high");
  a_od_no_pullup: assert property (@(posedge sys_clk) disable iff (!rst_n)
    pullup_en.p5 == 4'h0)
    else $error("open-drain pull-up on");
  a_seg_no_drive: assert property (@(posedge sys_clk) disable iff (!rst_n)
    seg8_r[0] && port8_segment_select[0] |-> pad_oe_n.p8[0])
    else $error("segment pin driven");
  a_wr_latch: assert property (@(posedge sys_clk) disable iff (!rst_n)
    bus_req.wr && bus_req.addr == mpgc_pkg::ADDR_P0 |=> ##1
    pad_out.p0 == $past(bus_req.wdata, 2))
    else $error("latch write not on pins");
  a_dir_fixed: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $past(bus_req.rd) && $past(bus_req.addr) == mpgc_pkg::ADDR_DIR5
    |-> bus_rdata[7:4] == 4'hf)
    else $error("unused direction bits not one");
  // Port0 pads follow its direction and latch one edge later; the edge after reset is skipped
  a_out_follow: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $past(rst_n)
    |-> pad_oe_n.p0 == $past(dir_r.p0) && pad_out.p0 == $past(lat_r.p0))
    else $error("port0 drive not from direction and latch");
  // Open-drain pin pulls low only for direction zero and latch zero
  a_od_drive_low: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $past(rst_n)
    |-> pad_oe_n.p5 == ($past(dir_r.p5) | $past(lat_r.p5)))
    else $error("open-drain enable wrong");
  // No output-mode pin of ports 0 to 3 ever has its pull-up on
  a_pu_inputs: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (~pad_oe_n.p0 & pullup_en.p0) == 8'h00 && (~pad_oe_n.p1 & pullup_en.p1) == 2'h0
    && (~pad_oe_n.p2 & pullup_en.p2) == 6'h00
    && (~pad_oe_n.p3 & pullup_en.p3) == 5'h00)
    else $error("pull-up on an output pin");
  a_pu_follow: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $past(rst_n)
    |-> pullup_en.p0 == ($past(pu0_r) & $past(dir_r.p0)))
    else $error("port0 pull-up not select and input");
  // Segment-owned pins read zero on both shared ports
  a_p7_seg_zero: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $past(bus_req.rd) && $past(bus_req.addr) == mpgc_pkg::ADDR_P7
    |-> (bus_rdata[3:0] & $past(seg7_r)) == 4'h0)
    else $error("port7 segment pin read non-zero");
  a_p8_seg_zero: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $past(bus_req.rd) && $past(bus_req.addr) == mpgc_pkg::ADDR_P8
    |-> (bus_rdata & $past(seg8_r)) == 8'h00)
    else $error("port8 segment pin read non-zero");
  // Detector pins keep following port3 even when it drives
  a_irq_follow: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $past(rst_n)
    |-> ext_irq_pins == $past(pad_s2_r.p3[3:0]))
    else $error("detector pins lost the pin level");
  // Reads never touch the latches, and an idle bus reads zero
  a_rd_keeps_latch: assert property (@(posedge sys_clk) disable iff (!rst_n)
    bus_req.rd && !bus_req.wr
    |=> lat_r == $past(lat_r))
    else $error("read changed a latch");
  a_rd_idle_zero: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $past(rst_n) && !$past(bus_req.rd)
    |-> bus_rdata == 8'h00)
    else $error("read data without a read");
  // A bit write to the port3 direction register leaves every unmasked bit as it was
  a_dir_bit_write: assert property (@(posedge sys_clk) disable iff (!rst_n)
    bus_req.wr && bus_req.addr == mpgc_pkg::ADDR_DIR3
    |=> ((dir_r.p3 ^ $past(dir_r.p3)) & ~$past(bus_req.bmask[4:0])) == 5'h00)
    else $error("bit write changed an unmasked bit");
  // Select outputs mirror the select registers one edge later
  a_seg_follow: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $past(rst_n)
    |-> port8_segment_select == $past(seg8_r) && port7_segment_select == $past(seg7_r))
    else $error("segment select outputs stale");
  c_out_mode: cover property (@(posedge sys_clk) pad_oe_n.p0 == 8'h00);
  c_od_low: cover property (@(posedge sys_clk) pad_oe_n.p5 != 4'hf);
  c_seg_sel: cover property (@(posedge sys_clk) port8_segment_select != 8'h00);
  c_bit_write: cover property (@(posedge sys_clk) bus_req.wr && bus_req.bmask != 8'hff);
  c_pu_on: cover property (@(posedge sys_clk) pullup_en.p1 != 2'h0);

endmodule // mpgc_top

`default_nettype wire

// *** hw/mpgc_pkg.sv ***
// Package for the multi-port GPIO control block: addresses, widths, resets.
// Assumes an 8-bit CPU special-register bus with 16-bit byte addresses.
package mpgc_pkg;
  localparam int          P0_W        = 8;
  localparam int          P1_W        = 2;
  localparam int          P2_W        = 6;
  localparam int          P3_W        = 5;
  localparam int          P5_W        = 4;
  localparam int          P6_W        = 8;
  localparam int          P7_W        = 4;
  localparam int          P8_W        = 8;
  // Port data addresses (latch write, pin/latch read)
  localparam logic [15:0] ADDR_P0     = 16'hff00;
  localparam logic [15:0] ADDR_P1     = 16'hff01;
  localparam logic [15:0] ADDR_P2     = 16'hff02;
  localparam logic [15:0] ADDR_P3     = 16'hff03;
  localparam logic [15:0] ADDR_P5     = 16'hff05;
  localparam logic [15:0] ADDR_P6     = 16'hff06;
  localparam logic [15:0] ADDR_P7     = 16'hff07;
  localparam logic [15:0] ADDR_P8     = 16'hff08;
  // Direction registers
  localparam logic [15:0] ADDR_DIR0   = 16'hff20;
  localparam logic [15:0] ADDR_DIR1   = 16'hff21;
  localparam logic [15:0] ADDR_DIR2   = 16'hff22;
  localparam logic [15:0] ADDR_DIR3   = 16'hff23;
  localparam logic [15:0] ADDR_DIR5   = 16'hff25;
  localparam logic [15:0] ADDR_DIR8   = 16'hff28;
  // Pull-up selection registers
  localparam logic [15:0] ADDR_PU0    = 16'hff30;
  localparam logic [15:0] ADDR_PU1    = 16'hff31;
  localparam logic [15:0] ADDR_PU2    = 16'hff32;
  localparam logic [15:0] ADDR_PU3    = 16'hff33;
  // Segment selection registers
  localparam logic [15:0] ADDR_SEG7   = 16'hff57;
  localparam logic [15:0] ADDR_SEG8   = 16'hff58;
  localparam logic [7:0]  DIR_RST     = 8'hff;
  localparam logic [7:0]  PU_RST      = 8'h00;
  localparam logic [7:0]  SEG_RST     = 8'h00;
  localparam logic [7:0]  LAT_RST     = 8'h00;

  // One CPU bus request
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [15:0] addr;
    logic [7:0]  wdata;
    logic [7:0]  bmask;
  } mpgc_req_t;

  // Pad drive for the bidirectional ports; oe_n low means driving
  typedef struct packed {
    logic [7:0] p0;
    logic [1:0] p1;
    logic [5:0] p2;
    logic [4:0] p3;
    logic [3:0] p5;
    logic [7:0] p8;
  } mpgc_pads_t;
endpackage

// *** dv/mpgc_board.sv ***
// Board-side model of the pins of the bidirectional ports.
// Assumes the testbench gives per-pin board levels and which pins it drives.
`timescale 1ns/10ps
`default_nettype none
module mpgc_board (
  input  wire mpgc_pkg::mpgc_pads_t pad_out,
  input  wire mpgc_pkg::mpgc_pads_t pad_oe_n,
  input  wire mpgc_pkg::mpgc_pads_t pullup_en,
  input  wire mpgc_pkg::mpgc_pads_t ext_val,
  input  wire mpgc_pkg::mpgc_pads_t ext_drv,
  output var  mpgc_pkg::mpgc_pads_t pad_in
);
  // Device wins where it drives; open pins float to the pull-up, else to a
  // flipped guess so a stale value never passes by luck
  always_comb begin
    pad_in = (~pad_oe_n & pad_out) | (pad_oe_n & ext_drv & ext_val)
           | (pad_oe_n & ~ext_drv & (pullup_en | ~ext_val));
  end
endmodule // mpgc_board
`default_nettype wire

// *** dv/tb_multi_port_gpio_control.sv ***
// Self-checking bench for the multi-port GPIO control block.
// Assumes mpgc_board on the pads and a bench-driven CPU bus at the falling edge.
`timescale 1ns/10ps
`default_nettype none
module tb_multi_port_gpio_control;
  logic                 sys_clk, rst_n;
  mpgc_pkg::mpgc_req_t  req;
  logic [7:0]           rdata, p6_in, kr, seg8, got, d, l, u, wm, en, ex, s, bm;
  logic [3:0]           p7_in, irq, seg7;
  mpgc_pkg::mpgc_pads_t pin, pout, poe_n, pu_en, ext_val, ext_drv;
  int                   err_count, check_count, cyc, seed, p, k, n;
  int                   idx [6] = '{0, 1, 2, 3, 5, 8};
  int                   wid [6] = '{8, 2, 6, 5, 4, 8};

  mpgc_top i_mpgc_top (.sys_clk(sys_clk), .rst_n(rst_n), .bus_req(req), .bus_rdata(rdata),
    .pad_in(pin), .p6_in(p6_in), .p7_in(p7_in), .pad_out(pout), .pad_oe_n(poe_n),
    .pullup_en(pu_en), .ext_irq_pins(irq), .key_return_inputs(kr),
    .port7_segment_select(seg7), .port8_segment_select(seg8));
  mpgc_board i_mpgc_board (.pad_out(pout), .pad_oe_n(poe_n), .pullup_en(pu_en),
    .ext_val(ext_val), .ext_drv(ext_drv), .pad_in(pin));

  // Clock at 40 MHz
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  // Pick one port field out of the pad struct, zero-extended
  function automatic logic [7:0] fld(input mpgc_pkg::mpgc_pads_t v, input int q);
    case (q)
      0: return v.p0;
      1: return {6'h00, v.p1};
      2: return {2'h0, v.p2};
      3: return {3'h0, v.p3};
      5: return {4'h0, v.p5};
      default: return v.p8;
    endcase
  endfunction

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One bus cycle from a falling edge; an idle cycle keeps strobes apart
  task automatic bus(input logic w, input logic [15:0] a, input logic [7:0] wd);
    req.wr = w;
    req.rd = ~w;
    req.addr = a;
    req.wdata = wd;
    req.bmask = bm;
    @(negedge sys_clk);
    got = rdata;
    req.wr = 1'b0;
    req.rd = 1'b0;
    @(negedge sys_clk);
  endtask

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // Hang guard, well above the roughly 830 cycles the tests need
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 6000) begin
      err_count++;
      wrap_up();
    end
  end

  initial begin
    seed = 44812;
    bm = 8'hff;
    rst_n = 1'b0;
    req = '0;
    ext_val = '0;
    ext_drv = '1;
    p6_in = 8'h00;
    p7_in = 4'h0;
    repeat (20) @(negedge sys_clk);
    rst_n = 1'b1;
    // Reset state of every direction and pull-up register and its pads
    for (k = 0; k < 6; k++) begin
      p = idx[k];
      wm = 8'((1 << wid[k]) - 1);
      bus(1'b0, 16'hff20 + 16'(p), 8'h00);
      check(got, 8'hff);
      check(fld(poe_n, p), wm);
      check(fld(pu_en, p), 8'h00);
      if (p < 4) begin
        bus(1'b0, 16'hff30 + 16'(p), 8'h00);
        check(got, 8'h00);
      end
    end
    bus(1'b0, 16'hff40, 8'h00);
    check(got, 8'h00);
    $display("test reset done");
    // Random latch, direction and pull-up per port, corners first
    for (n = 0; n < 48; n++) begin
      k = n % 6;
      p = idx[k];
      wm = 8'((1 << wid[k]) - 1);
      d = (n < 6) ? 8'h00 : (n < 12) ? 8'hff : 8'($random(seed));
      l = 8'($random(seed));
      u = (p < 4) ? 8'($random(seed)) : 8'h00;
      ext_val = 34'({$random(seed), $random(seed)});
      bus(1'b1, 16'hff00 + 16'(p), l);
      bus(1'b1, 16'hff20 + 16'(p), d);
      if (p < 4) bus(1'b1, 16'hff30 + 16'(p), u);
      repeat (6) @(negedge sys_clk);
      en = ~d & wm & ((p == 5) ? ~l : 8'hff);
      check(~fld(poe_n, p) & wm, en);
      check(fld(pout, p) & en, (p == 5) ? 8'h00 : (l & en));
      check(fld(pu_en, p), u & d & wm);
      ex = ((l & ~d) | (fld(ext_val, p) & d)) & wm;
      if (p == 0) check(kr, ex);
      if (p == 3) check({4'h0, irq}, ex & 8'h0f);
      bus(1'b0, 16'hff20 + 16'(p), 8'h00);
      check(got, d | ~wm);
      bus(1'b0, 16'hff00 + 16'(p), 8'h00);
      check(got & wm, ex);
    end
    $display("test random ports done");
    // Latch written in input mode shows only once output is enabled
    bus(1'b1, 16'hff20, 8'hff);
    bus(1'b1, 16'hff00, 8'h5a);
    repeat (3) @(negedge sys_clk);
    check(poe_n.p0, 8'hff);
    // Hand-driven write: pads must still be inputs between the two edges
    req.addr = 16'hff20;
    req.wdata = 8'h00;
    req.wr = 1'b1;
    @(negedge sys_clk);
    req.wr = 1'b0;
    check(poe_n.p0, 8'hff);
    @(negedge sys_clk);
    check(poe_n.p0, 8'h00);
    check(pout.p0, 8'h5a);
    $display("test input-mode latch done");
    // Timer output set up by a bit write: latch low, then one direction bit
    ext_val = '1;
    bus(1'b1, 16'hff03, 8'h00);
    bus(1'b1, 16'hff23, 8'hff);
    bm = 8'h01;
    bus(1'b1, 16'hff23, 8'h00);
    bm = 8'hff;
    bus(1'b0, 16'hff23, 8'h00);
    check(got, 8'hfe);
    repeat (3) @(negedge sys_clk);
    check({3'h0, poe_n.p3}, 8'h1e);
    check({3'h0, pout.p3}, 8'h00);
    check({4'h0, irq}, 8'h0e);
    $display("test timer output bit write done");
    // Undriven inputs with pull-up selected read high
    bus(1'b1, 16'hff21, 8'hff);
    bus(1'b1, 16'hff31, 8'h03);
    ext_drv = '0;
    repeat (5) @(negedge sys_clk);
    bus(1'b0, 16'hff01, 8'h00);
    check(got & 8'h03, 8'h03);
    ext_drv = '1;
    $display("test pull-up float done");
    // Segment selects, input-only ports
    s = 8'($random(seed));
    p6_in = 8'($random(seed));
    p7_in = 4'($random(seed));
    bus(1'b1, 16'hff28, 8'h00);
    bus(1'b1, 16'hff58, s);
    bus(1'b1, 16'hff57, 8'h0a);
    repeat (3) @(negedge sys_clk);
    check(poe_n.p8, s);
    check(seg8, s);
    check({4'h0, seg7}, 8'h0a);
    bus(1'b0, 16'hff07, 8'h00);
    check(got & 8'h0f, {4'h0, p7_in & 4'h5});
    bus(1'b0, 16'hff06, 8'h00);
    check(got, p6_in);
    bus(1'b1, 16'hff08, 8'h3c);
    bus(1'b0, 16'hff08, 8'h00);
    check(got, 8'h3c & ~s);
    $display("test segment and input ports done");
    // Mid-run reset puts everything back, selects and pull-ups included
    rst_n = 1'b0;
    repeat (2) @(negedge sys_clk);
    rst_n = 1'b1;
    check(poe_n.p8, 8'hff);
    check(seg8, 8'h00);
    bus(1'b0, 16'hff31, 8'h00);
    check(got, 8'h00);
    $display("test mid-run reset done");
    wrap_up();
  end
endmodule // tb_multi_port_gpio_control
`default_nettype wire
